// ---- hdl/cmb_buffer.sv ----
// can message buffer object: register port, transmit and receive packing
`timescale 1ns/100ps
`default_nettype none
`include "cmb_params.svh"
module cmb_buffer (
    // clock and reset
    input  wire logic              sys_clk_in,
    input  wire logic              rst_in,
    // register port
    input  wire logic [5:0]        reg_addr_in,
    input  wire logic [15:0]       reg_wdata_in,
    input  wire logic              reg_wr_in,
    input  wire logic              reg_rd_in,
    output logic      [15:0]       reg_rdata_out,
    // transmit side toward the protocol engine
    input  wire logic              tx_start_in,
    output cmb_pkg::cmb_hdr_t      tx_hdr_out,
    output logic                   tx_hdr_valid_out,
    output logic      [7:0]        tx_byte_out,
    output logic                   tx_byte_valid_out,
    input  wire logic              tx_byte_ready_in,
    output logic                   tx_done_out,
    // receive side from the protocol engine
    input  wire cmb_pkg::cmb_hdr_t rx_hdr_in,
    input  wire logic              rx_hdr_valid_in,
    output logic                   rx_hdr_ready_out,
    input  wire logic [7:0]        rx_byte_in,
    input  wire logic              rx_byte_valid_in,
    output logic                   rx_byte_ready_out,
    output logic                   rx_done_out,
    // status
    output logic                   busy_out
);
    // ----------------------------------------
    // state
    // ----------------------------------------
    cmb_pkg::cmb_state_t state_q;
    cmb_pkg::cmb_hdr_t   hdr_q;
    logic                order_q;
    logic [15:0]         hi_q;
    logic [15:0]         lo_q;
    logic [3:0]          cnt_q;
    logic [3:0]          nbytes_q;
    logic [7:0]          hold_q;
    logic                rd_pend_q;
    logic [15:0]         a_data;
    logic [15:0]         b_data;
    logic [2:0]          b_idx;
    logic                e_wr;
    logic [2:0]          e_idx;
    logic [15:0]         e_data;
    logic                mem_wr;
    logic [2:0]          mem_idx;
    logic [15:0]         mem_data;
    logic [2:0]          byte_word;
    logic                byte_high;
    logic                rx_take;
    logic                rx_last;

    // ----------------------------------------
    // helpers
    // ----------------------------------------
    // lengths past eight are clamped so at most eight bytes ever move
    function automatic logic [3:0] clamp8(input logic [3:0] dlc);
        clamp8 = (dlc >= `CMB_MAX_BYTES) ? `CMB_MAX_BYTES : dlc;
    endfunction

    // byte k lands in word 5-k/2 high first, or word 2+k/2 low first
    always_comb begin
        if (!order_q) begin
            byte_word = 3'(3'h5 - cnt_q[3:1]);
            byte_high = ~cnt_q[0];
        end else begin
            byte_word = 3'(3'h2 + cnt_q[3:1]);
            byte_high = cnt_q[0];
        end
    end

    assign busy_out          = (state_q != cmb_pkg::ST_IDLE);
    assign rx_hdr_ready_out  = (state_q == cmb_pkg::ST_IDLE);
    assign rx_byte_ready_out = (state_q == cmb_pkg::ST_RX_DATA) && !reg_wr_in;
    assign rx_take           = rx_byte_valid_in && rx_byte_ready_out;
    assign rx_last           = (4'(cnt_q + 4'h1) == nbytes_q);
    assign tx_byte_valid_out = (state_q == cmb_pkg::ST_TX_BYTE);

    // ----------------------------------------
    // memory and write arbitration
    // ----------------------------------------
    // software writes win; the engine only writes while its ready is low-safe
    assign mem_wr   = reg_wr_in ? !reg_addr_in[5] : e_wr;
    assign mem_idx  = reg_wr_in ? reg_addr_in[4:2] : e_idx;
    assign mem_data = reg_wr_in ? reg_wdata_in : e_data;

    cmb_mem #(
        .WIDTH(16),
        .DEPTH(8)
    ) u_mem (
        .sys_clk_in(sys_clk_in),
        .rst_in    (rst_in),
        .wr_en_in  (mem_wr),
        .wr_idx_in (mem_idx),
        .wr_data_in(mem_data),
        .a_idx_in  (reg_addr_in[4:2]),
        .a_data_out(a_data),
        .b_idx_in  (b_idx),
        .b_data_out(b_data)
    );

    // engine read and write requests per state
    always_comb begin
        b_idx  = 3'h0;
        e_wr   = 1'b0;
        e_idx  = 3'h0;
        e_data = 16'h0000;
        unique case (state_q)
            cmb_pkg::ST_TX_HI: b_idx = 3'(`CMB_OFS_IDENT_HIGH >> 2);
            cmb_pkg::ST_TX_LO: b_idx = 3'(`CMB_OFS_IDENT_LOW >> 2);
            cmb_pkg::ST_TX_ST, cmb_pkg::ST_RX_STRD: b_idx = 3'(`CMB_OFS_STATUS_CTRL >> 2);
            cmb_pkg::ST_TX_RD: b_idx = byte_word;
            cmb_pkg::ST_RX_HI: begin
                e_wr  = !reg_wr_in;
                e_idx = 3'(`CMB_OFS_IDENT_HIGH >> 2);
                if (hdr_q.ide) begin
                    // substitute bit written as sampled, never forced
                    e_data = {hdr_q.id[28:18], hdr_q.srr, 1'b1, hdr_q.id[17:15]};
                end else begin
                    e_data = {hdr_q.id[28:18], hdr_q.rtr, 1'b0, 3'h0};
                end
            end
            cmb_pkg::ST_RX_LO: begin
                e_wr   = !reg_wr_in;
                e_idx  = 3'(`CMB_OFS_IDENT_LOW >> 2);
                e_data = {hdr_q.id[14:0], hdr_q.rtr};
            end
            cmb_pkg::ST_RX_DATA: begin
                // pairs are written whole; an odd last byte fills its partner with zero
                e_wr  = rx_take && (cnt_q[0] || rx_last);
                e_idx = byte_word;
                if (cnt_q[0]) begin
                    e_data = byte_high ? {rx_byte_in, hold_q} : {hold_q, rx_byte_in};
                end else begin
                    e_data = byte_high ? {rx_byte_in, 8'h00} : {8'h00, rx_byte_in};
                end
            end
            cmb_pkg::ST_RX_STWR: begin
                e_wr   = !reg_wr_in;
                e_idx  = 3'(`CMB_OFS_STATUS_CTRL >> 2);
                e_data = {hdr_q.dlc, hi_q[11:0]};
            end
            default: b_idx = 3'h0;
        endcase
    end

    // ----------------------------------------
    // register port
    // ----------------------------------------
    always_ff @(posedge sys_clk_in or posedge rst_in) begin
        if (rst_in) begin
            order_q <= `CMB_CTRL_RESET;
        end else if (reg_wr_in && reg_addr_in == `CMB_OFS_CTRL) begin
            order_q <= reg_wdata_in[`CMB_CTRL_ORDER];
        end
    end

    always_ff @(posedge sys_clk_in or posedge rst_in) begin
        if (rst_in) begin
            rd_pend_q <= 1'b0;
            hold_q    <= 8'h00;
        end else begin
            rd_pend_q <= reg_rd_in;
            if (rx_take && !cnt_q[0]) begin
                hold_q <= rx_byte_in;
            end
        end
    end

    // read data only in the cycle after the strobe; unmapped reads give zero
    logic [5:0] rd_addr_q;
    always_ff @(posedge sys_clk_in or posedge rst_in) begin
        if (rst_in) begin
            rd_addr_q <= 6'h00;
        end else begin
            rd_addr_q <= reg_addr_in;
        end
    end

    always_comb begin
        reg_rdata_out = 16'h0000;
        if (rd_pend_q) begin
            if (!rd_addr_q[5]) begin
                reg_rdata_out = a_data;
            end else if (rd_addr_q == `CMB_OFS_CTRL) begin
                reg_rdata_out = {15'h0000, order_q};
            end else if (rd_addr_q == `CMB_OFS_ENGINE_STAT) begin
                reg_rdata_out = {11'h000, busy_out, state_q};
            end
        end
    end

    // ----------------------------------------
    // sequencer
    // ----------------------------------------
    always_ff @(posedge sys_clk_in or posedge rst_in) begin
        if (rst_in) begin
            state_q          <= cmb_pkg::ST_IDLE;
            hdr_q            <= '0;
            hi_q             <= 16'h0000;
            lo_q             <= 16'h0000;
            cnt_q            <= 4'h0;
            nbytes_q         <= 4'h0;
            tx_hdr_out       <= '0;
            tx_hdr_valid_out <= 1'b0;
            tx_byte_out      <= 8'h00;
            tx_done_out      <= 1'b0;
            rx_done_out      <= 1'b0;
        end else begin
            tx_hdr_valid_out <= 1'b0;
            tx_done_out      <= 1'b0;
            rx_done_out      <= 1'b0;
            unique case (state_q)
                cmb_pkg::ST_IDLE: begin
                    cnt_q <= 4'h0;
                    if (rx_hdr_valid_in) begin
                        hdr_q    <= rx_hdr_in;
                        // remote frames store no data bytes
                        nbytes_q <= rx_hdr_in.rtr ? 4'h0 : clamp8(rx_hdr_in.dlc);
                        state_q  <= cmb_pkg::ST_RX_HI;
                    end else if (tx_start_in) begin
                        state_q <= cmb_pkg::ST_TX_HI;
                    end
                end
                cmb_pkg::ST_TX_HI: state_q <= cmb_pkg::ST_TX_LO;
                cmb_pkg::ST_TX_LO: begin
                    hi_q    <= b_data;
                    state_q <= cmb_pkg::ST_TX_ST;
                end
                cmb_pkg::ST_TX_ST: begin
                    lo_q    <= b_data;
                    state_q <= cmb_pkg::ST_TX_HDR;
                end
                cmb_pkg::ST_TX_HDR: begin
                    tx_hdr_out.ide <= hi_q[`CMB_HI_IDE];
                    tx_hdr_out.dlc <= b_data[`CMB_DLC_MSB:`CMB_DLC_LSB];
                    if (hi_q[`CMB_HI_IDE]) begin
                        // srr passed through untouched: software owns it
                        tx_hdr_out.srr <= hi_q[`CMB_HI_RTR_SRR];
                        tx_hdr_out.rtr <= lo_q[`CMB_LO_RTR];
                        tx_hdr_out.id  <= {hi_q[15:5], hi_q[2:0], lo_q[15:1]};
                    end else begin
                        tx_hdr_out.srr <= 1'b0;
                        tx_hdr_out.rtr <= hi_q[`CMB_HI_RTR_SRR];
                        tx_hdr_out.id  <= {hi_q[15:5], 18'h0_0000};
                    end
                    nbytes_q <= (hi_q[`CMB_HI_IDE] ? lo_q[`CMB_LO_RTR] : hi_q[`CMB_HI_RTR_SRR])
                                ? 4'h0 : clamp8(b_data[`CMB_DLC_MSB:`CMB_DLC_LSB]);
                    hi_q             <= b_data;
                    tx_hdr_valid_out <= 1'b1;
                    state_q          <= cmb_pkg::ST_TX_RD;
                end
                cmb_pkg::ST_TX_RD: begin
                    if (cnt_q == nbytes_q) begin
                        tx_done_out <= 1'b1;
                        state_q     <= cmb_pkg::ST_IDLE;
                    end else begin
                        state_q <= cmb_pkg::ST_TX_WAIT;
                    end
                end
                cmb_pkg::ST_TX_WAIT: begin
                    tx_byte_out <= byte_high ? b_data[15:8] : b_data[7:0];
                    state_q     <= cmb_pkg::ST_TX_BYTE;
                end
                cmb_pkg::ST_TX_BYTE: begin
                    if (tx_byte_ready_in) begin
                        cnt_q   <= 4'(cnt_q + 4'h1);
                        state_q <= cmb_pkg::ST_TX_RD;
                    end
                end
                cmb_pkg::ST_RX_HI: begin
                    if (!reg_wr_in) begin
                        state_q <= hdr_q.ide ? cmb_pkg::ST_RX_LO : cmb_pkg::ST_RX_DATA;
                    end
                end
                cmb_pkg::ST_RX_LO: begin
                    if (!reg_wr_in) begin
                        state_q <= cmb_pkg::ST_RX_DATA;
                    end
                end
                cmb_pkg::ST_RX_DATA: begin
                    if (nbytes_q == 4'h0) begin
                        state_q <= cmb_pkg::ST_RX_STRD;
                    end else if (rx_take) begin
                        cnt_q <= 4'(cnt_q + 4'h1);
                        if (rx_last) begin
                            state_q <= cmb_pkg::ST_RX_STRD;
                        end
                    end
                end
                cmb_pkg::ST_RX_STRD: state_q <= cmb_pkg::ST_RX_STWR;
                cmb_pkg::ST_RX_STWR: begin
                    if (!reg_wr_in) begin
                        rx_done_out <= 1'b1;
                        state_q     <= cmb_pkg::ST_IDLE;
                    end else begin
                        state_q <= cmb_pkg::ST_RX_STRD;
                    end
                end
                default: state_q <= cmb_pkg::ST_IDLE;
            endcase
            if (state_q == cmb_pkg::ST_RX_STRD) begin
                hi_q <= 16'h0000;
            end
            if (state_q == cmb_pkg::ST_RX_STWR || state_q == cmb_pkg::ST_RX_STRD) begin
                hi_q <= b_data;
            end
        end
    end

    // ----------------------------------------
    // checks
    // ----------------------------------------
    logic [3:0] sent_q;
    always_ff @(posedge sys_clk_in or posedge rst_in) begin
        if (rst_in) begin
            sent_q <= 4'h0;
        end else if (tx_hdr_valid_out) begin
            sent_q <= 4'h0;
        end else if (tx_byte_valid_out && tx_byte_ready_in) begin
            sent_q <= 4'(sent_q + 4'h1);
        end
    end

    sequence s_hdr_std;
        tx_hdr_valid_out && !tx_hdr_out.ide;
    endsequence

    sequence s_hdr_remote;
        tx_hdr_valid_out && tx_hdr_out.rtr;
    endsequence

    property p_std_low_zero;
        @(posedge sys_clk_in) disable iff (rst_in) s_hdr_std |-> tx_hdr_out.id[17:0] == 18'h0_0000;
    endproperty
    a_std_low_zero: assert property (p_std_low_zero) else $error("standard id carries low bits");

    property p_remote_no_bytes;
        @(posedge sys_clk_in) disable iff (rst_in) s_hdr_remote |-> !tx_byte_valid_out [*3];
    endproperty
    a_remote_no_bytes: assert property (p_remote_no_bytes) else $error("remote frame sent data");

    property p_max_eight;
        @(posedge sys_clk_in) disable iff (rst_in) sent_q <= 4'h8;
    endproperty
    a_max_eight: assert property (p_max_eight) else $error("more than eight bytes sent");

    property p_done_count;
        @(posedge sys_clk_in) disable iff (rst_in)
            tx_done_out |-> sent_q == (tx_hdr_out.rtr ? 4'h0 : clamp8(tx_hdr_out.dlc));
    endproperty
    a_done_count: assert property (p_done_count) else $error("sent count differs from length");

    property p_rx_ext_hi;
        @(posedge sys_clk_in) disable iff (rst_in)
            mem_wr && !reg_wr_in && state_q == cmb_pkg::ST_RX_HI && hdr_q.ide
            |-> mem_data[4] == hdr_q.srr && mem_data[3] && mem_idx == 3'h7;
    endproperty
    a_rx_ext_hi: assert property (p_rx_ext_hi) else $error("extended upper word packed wrong");

    property p_rx_std_hi;
        @(posedge sys_clk_in) disable iff (rst_in)
            mem_wr && !reg_wr_in && state_q == cmb_pkg::ST_RX_HI && !hdr_q.ide
            |-> mem_data[4] == hdr_q.rtr && !mem_data[3] && mem_data[15:5] == hdr_q.id[28:18];
    endproperty
    a_rx_std_hi: assert property (p_rx_std_hi) else $error("standard upper word packed wrong");

    property p_first_byte_word;
        @(posedge sys_clk_in) disable iff (rst_in)
            state_q == cmb_pkg::ST_TX_RD && cnt_q == 4'h0 |-> b_idx == (order_q ? 3'h2 : 3'h5);
    endproperty
    a_first_byte_word: assert property (p_first_byte_word) else $error("first byte from wrong word");

    property p_unmapped_zero;
        @(posedge sys_clk_in) disable iff (rst_in)
            reg_rd_in && reg_addr_in[5] && reg_addr_in != `CMB_OFS_CTRL && reg_addr_in != `CMB_OFS_ENGINE_STAT
            |=> reg_rdata_out == 16'h0000;
    endproperty
    a_unmapped_zero: assert property (p_unmapped_zero) else $error("unmapped read not zero");
endmodule // cmb_buffer
`default_nettype wire

// ---- hdl/cmb_mem.sv ----
// eight-word buffer memory, two registered read ports, one write port
`timescale 1ns/100ps
`default_nettype none
module cmb_mem #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 8
) (
    // clock and reset
    input  wire logic                     sys_clk_in,
    input  wire logic                     rst_in,
    // write port
    input  wire logic                     wr_en_in,
    input  wire logic [$clog2(DEPTH)-1:0] wr_idx_in,
    input  wire logic [WIDTH-1:0]         wr_data_in,
    // read ports
    input  wire logic [$clog2(DEPTH)-1:0] a_idx_in,
    output logic      [WIDTH-1:0]         a_data_out,
    input  wire logic [$clog2(DEPTH)-1:0] b_idx_in,
    output logic      [WIDTH-1:0]         b_data_out
);
    logic [WIDTH-1:0] mem_q [DEPTH];

    if (DEPTH < 2 || WIDTH < 1) begin : g_chk
        $error("cmb_mem: unsupported geometry");
    end

    always_ff @(posedge sys_clk_in) begin
        if (wr_en_in) begin
            mem_q[wr_idx_in] <= wr_data_in;
        end
    end

    always_ff @(posedge sys_clk_in or posedge rst_in) begin
        if (rst_in) begin
            a_data_out <= '0;
            b_data_out <= '0;
        end else begin
            a_data_out <= mem_q[a_idx_in];
            b_data_out <= mem_q[b_idx_in];
        end
    end
endmodule // cmb_mem
`default_nettype wire

// ---- hdl/cmb_params.svh ----
// constants of the can message buffer: offsets, fields, reset values
`ifndef CMB_PARAMS_SVH
`define CMB_PARAMS_SVH
// ----------------------------------------
// word offsets inside one buffer
// ----------------------------------------
`define CMB_OFS_STATUS_CTRL  6'h00
`define CMB_OFS_TIMESTAMP    6'h04
`define CMB_OFS_DATA_7_8     6'h08
`define CMB_OFS_DATA_5_6     6'h0c
`define CMB_OFS_DATA_3_4     6'h10
`define CMB_OFS_DATA_1_2     6'h14
`define CMB_OFS_IDENT_LOW    6'h18
`define CMB_OFS_IDENT_HIGH   6'h1c
`define CMB_OFS_CTRL         6'h20
`define CMB_OFS_ENGINE_STAT  6'h24
// ----------------------------------------
// field positions
// ----------------------------------------
`define CMB_DLC_MSB          15
`define CMB_DLC_LSB          12
`define CMB_HI_BASE_MSB      15
`define CMB_HI_BASE_LSB      5
`define CMB_HI_RTR_SRR       4
`define CMB_HI_IDE           3
`define CMB_HI_EXT_MSB       2
`define CMB_LO_RTR           0
`define CMB_CTRL_ORDER       0
`define CMB_MAX_BYTES        4'h8
`define CMB_CTRL_RESET       1'h0
`endif

// ---- hdl/cmb_pkg.sv ----
// types of the can message buffer
package cmb_pkg;
    // ----------------------------------------
    // frame header passed to and from the protocol engine
    // ----------------------------------------
    typedef struct packed {
        logic        ide;
        logic        srr;
        logic        rtr;
        logic [28:0] id;
        logic [3:0]  dlc;
    } cmb_hdr_t;

    typedef enum logic [3:0] {
        ST_IDLE    = 4'b0000,
        ST_TX_HI   = 4'b0001,
        ST_TX_LO   = 4'b0010,
        ST_TX_ST   = 4'b0011,
        ST_TX_HDR  = 4'b0100,
        ST_TX_RD   = 4'b0101,
        ST_TX_WAIT = 4'b0110,
        ST_TX_BYTE = 4'b0111,
        ST_RX_HI   = 4'b1000,
        ST_RX_LO   = 4'b1001,
        ST_RX_DATA = 4'b1010,
        ST_RX_STRD = 4'b1011,
        ST_RX_STWR = 4'b1100
    } cmb_state_t;
endpackage

// ---- tb/can_message_buffer_format_tb.sv ----
// self-checking bench of the can message buffer
`timescale 1ns/100ps
`default_nettype none
module can_message_buffer_format_tb;
    logic sys_clk_in = 1'b0, rst_in = 1'b1, reg_wr_in = 1'b0, reg_rd_in = 1'b0, tx_start_in = 1'b0, slow = 1'b0;
    logic rx_hdr_valid_in = 1'b0, rx_byte_valid_in = 1'b0;
    logic tx_hdr_valid_out, tx_byte_valid_out, tx_byte_ready_in, tx_done_out;
    logic rx_hdr_ready_out, rx_byte_ready_out, rx_done_out, busy_out;
    logic [5:0]  reg_addr_in = 6'h00;
    logic [15:0] reg_wdata_in = 16'h0000, reg_rdata_out, rd_v;
    logic [15:0] w [0:7];
    logic [7:0]  rx_byte_in = 8'h00, tx_byte_out;
    cmb_pkg::cmb_hdr_t rx_hdr_in = '0, tx_hdr_out, got_h;
    int err_total = 0, total_checks = 0, cyc = 0;
    cmb_buffer dut_u (.sys_clk_in, .rst_in, .reg_addr_in, .reg_wdata_in, .reg_wr_in, .reg_rd_in, .reg_rdata_out,
        .tx_start_in, .tx_hdr_out, .tx_hdr_valid_out, .tx_byte_out, .tx_byte_valid_out, .tx_byte_ready_in,
        .tx_done_out, .rx_hdr_in, .rx_hdr_valid_in, .rx_hdr_ready_out, .rx_byte_in, .rx_byte_valid_in,
        .rx_byte_ready_out, .rx_done_out, .busy_out);
    cmb_engine_model eng_u (.sys_clk_in, .rst_in, .slow_in(slow), .clr_in(tx_hdr_valid_out),
        .valid_in(tx_byte_valid_out), .byte_in(tx_byte_out), .ready_out(tx_byte_ready_in));
    always #12.5 sys_clk_in = ~sys_clk_in;
    // ----------------------------------------
    // tasks
    // ----------------------------------------
    task automatic conclude();
        $display("checks %0d errors %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string nm);
        total_checks++;
        if (seen !== exp) begin
            err_total++;
            $display("wrong value %s expected %0h seen %0h", nm, exp, seen);
        end
    endtask
    task automatic wr(input logic [5:0] a, input logic [15:0] d);
        @(posedge sys_clk_in);
        reg_addr_in <= a;
        reg_wdata_in <= d;
        reg_wr_in <= 1'b1;
        @(posedge sys_clk_in);
        reg_wr_in <= 1'b0;
    endtask
    task automatic rd(input logic [5:0] a);
        @(posedge sys_clk_in);
        reg_addr_in <= a;
        reg_rd_in <= 1'b1;
        @(posedge sys_clk_in);
        reg_rd_in <= 1'b0;
        @(negedge sys_clk_in);
        rd_v = reg_rdata_out;
    endtask
    function automatic logic [7:0] exb(int k, logic o);
        logic [15:0] x;
        x = o ? w[2 + k / 2] : w[5 - k / 2];
        return (k[0] ^ o) ? x[7:0] : x[15:8];
    endfunction
    task automatic tx(input logic [15:0] st, lo, hi, input logic o);
        int nb;
        logic r;
        w[0] = st;
        w[6] = lo;
        w[7] = hi;
        r = hi[3] ? lo[0] : hi[4];
        nb = r ? 0 : (st[15] ? 8 : int'(st[14:12]));
        got_h = '0;
        wr(6'h00, st);
        wr(6'h18, lo);
        wr(6'h1c, hi);
        wr(6'h20, {15'h0000, o});
        @(posedge sys_clk_in) tx_start_in <= 1'b1;
        @(posedge sys_clk_in) tx_start_in <= 1'b0;
        for (int i = 0; i < 200 && tx_done_out !== 1'b1; i++) begin
            @(negedge sys_clk_in);
            if (tx_hdr_valid_out === 1'b1) got_h = tx_hdr_out;
        end
        chk(tx_done_out, 1'b1, "tx done");
        chk(got_h.ide, hi[3], "ide");
        chk(got_h.rtr, r, "rtr");
        chk(got_h.srr, hi[3] & hi[4], "srr");
        chk(got_h.id, hi[3] ? {hi[15:5], hi[2:0], lo[15:1]} : {hi[15:5], 18'h0_0000}, "id");
        chk(got_h.dlc, st[15:12], "dlc");
        chk(eng_u.n, nb, "byte count");
        for (int k = 0; k < nb; k++) chk(eng_u.got[k], exb(k, o), "tx byte");
    endtask
    task automatic rx(input cmb_pkg::cmb_hdr_t h);
        wr(6'h20, 16'h0000);
        @(posedge sys_clk_in);
        rx_hdr_in <= h;
        rx_hdr_valid_in <= 1'b1;
        @(posedge sys_clk_in) rx_hdr_valid_in <= 1'b0;
        for (int k = 0; k < 5; k++) begin
            rx_byte_in <= 8'hC0 + 8'(k);
            rx_byte_valid_in <= 1'b1;
            do @(negedge sys_clk_in); while (rx_byte_ready_out !== 1'b1);
            @(posedge sys_clk_in);
        end
        rx_byte_valid_in <= 1'b0;
        for (int i = 0; i < 60 && rx_done_out !== 1'b1; i++) @(negedge sys_clk_in);
        chk(rx_done_out, 1'b1, "rx done");
        chk(busy_out, 1'b0, "busy after rx");
        chk(rx_hdr_ready_out, 1'b1, "hdr ready after rx");
        rd(6'h1c);
        chk(rd_v, {h.id[28:18], h.srr, 1'b1, h.id[17:15]}, "ident high");
        rd(6'h18);
        chk(rd_v, {h.id[14:0], h.rtr}, "ident low");
        rd(6'h00);
        chk(rd_v[15:12], h.dlc, "rx dlc");
        for (int k = 0; k < 5; k++) begin
            rd(6'((5 - k / 2) * 4));
            chk(k[0] ? rd_v[7:0] : rd_v[15:8], 8'hC0 + 8'(k), "rx byte");
        end
    endtask
    // ----------------------------------------
    // sequence
    // ----------------------------------------
    always @(posedge sys_clk_in) begin
        cyc++;
        if (cyc == 20000) begin
            err_total++;
            conclude();
        end
    end
    initial begin
        for (int i = 0; i < 8; i++) w[i] = 16'h1357 + 16'(i) * 16'h2468;
        repeat (4) @(posedge sys_clk_in);
        rst_in <= 1'b0;
        for (int i = 0; i < 8; i++) wr(6'(i * 4), w[i]);
        for (int i = 0; i < 8; i++) begin
            rd(6'(i * 4));
            chk(rd_v, w[i], "buffer word");
        end
        rd(6'h28);
        chk(rd_v, 16'h0000, "unmapped");
        wr(6'h20, 16'h0001);
        rd(6'h20);
        chk(rd_v, 16'h0001, "order select");
        tx(16'h3000, 16'h1234, 16'hA5E5, 1'b0);
        tx(16'h2000, 16'h9C3B, 16'h6B1E, 1'b0);
        slow <= 1'b1;
        tx(16'hF000, 16'h9C3A, 16'h6B1E, 1'b1);
        slow <= 1'b0;
        tx(16'h4000, 16'h0000, 16'hA5F0, 1'b0);
        // srr clear on receive shows the bit is stored, not forced
        rx('{ide: 1'b1, srr: 1'b0, rtr: 1'b0, id: 29'h0ABC_DEF3, dlc: 4'h5});
        rd(6'h24);
        chk(rd_v, 16'h0000, "engine status idle");
        rd(6'h20);
        chk(rd_v, 16'h0000, "order select cleared");
        conclude();
    end
endmodule // can_message_buffer_format_tb
`default_nettype wire

// ---- tb/cmb_engine_model.sv ----
// protocol engine stand-in: takes transmit bytes, ready steady or toggling
`timescale 1ns/100ps
`default_nettype none
module cmb_engine_model (
    input  wire logic       sys_clk_in,
    input  wire logic       rst_in,
    input  wire logic       slow_in,
    input  wire logic       clr_in,
    input  wire logic       valid_in,
    input  wire logic [7:0] byte_in,
    output logic            ready_out
);
    logic [7:0] got [0:15];
    int         n;
    // a slow engine drops ready every other cycle to stall the buffer
    always_ff @(posedge sys_clk_in or posedge rst_in) begin
        if (rst_in) begin
            ready_out <= 1'b0;
            n <= 0;
        end else begin
            ready_out <= slow_in ? ~ready_out : 1'b1;
            if (clr_in) begin
                n <= 0;
            end else if (valid_in && ready_out) begin
                got[n[3:0]] <= byte_in;
                n <= n + 1;
            end
        end
    end
endmodule // cmb_engine_model
`default_nettype wire
